/* File: design/midrange_chip_select_unit.sv */
// midrange memory selects and the shared auxiliary select configuration,
// with an ahb-lite slave for the two configuration registers and a status word.
// assumes the bus unit pulses i_cyc_start in the address cycle of each bus
// cycle and i_cyc_end in its last cycle, both synchronous to i_clk.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps

// Functional notes
// [R1] midrange selects stay off until both configuration registers are written
// [R2] midrange selects follow the multiplexed bus, one register stage after start
// [R3] base bits 15..9 give address 19..13; low thirteen bits are zero
// [R4] software aligns the block base to the total block size
// [R5] software uses base zero only while the lower memory select is off
// [R6] software never places a 512K block at 80000h
// [R7] software keeps the midrange range clear of other select ranges
// [R8] midrange bit 2: 0 waits for external ready, 1 ignores it
// [R9] midrange bits 1..0 insert zero to three wait states
// [R10] auxiliary bits 14..8 one-hot total size; each select covers a quarter
// [R11] software sets exactly one block size bit
// [R12] auxiliary bit 7: 1 chip selects, 0 pins carry A1 and A2
// [R13] in address mode the upper pins show latched A2 and A1
// [R14] address mode starts after an auxiliary write alone
// [R15] auxiliary bit 6: 1 memory cycles, 0 I/O cycles for peripheral selects
// [R16] auxiliary bit 2 sets ready mode of the upper peripheral selects only
// [R17] auxiliary bits 1..0 give their zero to three wait states
// [R18] software clears programmable I/O mode and direction of the pins
// [R19] software writes ones into the reserved bits
// [R20] configuration registers hold no defined value after reset
// [R21] exactly one of four midrange selects, picked by address above quarter size
module midrange_chip_select_unit
    import midrange_cs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_cyc_start,
    input wire logic i_cyc_end,
    input wire logic [19:0] i_addr,
    input wire logic i_mem_cycle,
    input wire logic i_ext_ready,
    input wire logic [8:0] i_peripheral_base,
    input wire logic i_peripheral_base_valid,
    output logic [3:0] o_midrange_selects_n,
    output logic [1:0] o_upper_peripheral_pins,
    output logic o_cycle_ready
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // address bits 19..13+i compared for one-hot size bit i; zero size compares none
    function automatic logic [6:0] size_mask(input logic [6:0] m);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < 7; i++) begin
            r[i] = |(m & 7'((8'h01 << (i + 1)) - 8'h01));
        end
        return r;
    endfunction

    // the two address bits just above the quarter size
    function automatic logic [1:0] quarter_idx(input logic [6:0] m, input logic [19:0] a);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < 7; i++) begin
            if (m[i]) begin
                r = a[12 + i -: 2];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [15:0] mid_cfg_reg;
    logic [15:0] aux_cfg_reg;
    logic mid_written_reg;
    logic aux_written_reg;
    logic dp_write_reg;
    logic [9:0] dp_idx_reg;
    logic [19:0] lat_addr_reg;
    logic lat_mem_reg;
    logic [3:0] mid_sel_n_reg;
    logic [1:0] pins_reg;
    logic [1:0] grp_reg;
    logic addr_phase;
    logic wr_mid;
    logic wr_aux;
    logic [6:0] mid_base;
    logic [6:0] mid_size;
    logic mid_en;
    logic mid_hit;
    logic [1:0] mid_idx;
    logic pin_func;
    logic space_mem;
    logic pcs_cs_mode;
    logic pcs_addr_mode;
    logic pcs_blk;
    logic pcs5_hit;
    logic pcs6_hit;
    logic pcs_hit;
    logic [15:0] rd_word;

    wait_ctl_if mid_w();
    wait_ctl_if pcs_w();

    // ------------------------------------------------------------------
    // ahb-lite decode
    // ------------------------------------------------------------------
    // stalling on a frozen clock keeps the master from losing a write
    assign o_hreadyout = i_ce;
    assign o_hresp = 1'b0;
    assign addr_phase = i_hsel && i_htrans[1] && i_hready;
    assign wr_mid = dp_write_reg && (dp_idx_reg == MID_CFG_IDX);
    assign wr_aux = dp_write_reg && (dp_idx_reg == AUX_CFG_IDX);

    // address phase capture; only word transfers are expected, hsize unused
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            dp_write_reg <= 1'b0;
            dp_idx_reg <= 10'h000;
        end else if (i_ce) begin
            dp_write_reg <= addr_phase && i_hwrite;
            dp_idx_reg <= addr_phase ? i_haddr[11:2] : 10'h000;
        end
    end

    // no reset on the contents: unknown until software writes them
    always_ff @(posedge i_clk) begin // [R20]
        if (i_ce && wr_mid) begin
            mid_cfg_reg <= i_hwdata[15:0];
        end
        if (i_ce && wr_aux) begin
            aux_cfg_reg <= i_hwdata[15:0];
        end
    end

    // write-seen flags gate the outputs
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mid_written_reg <= 1'b0;
            aux_written_reg <= 1'b0;
        end else if (i_ce) begin
            mid_written_reg <= mid_written_reg || wr_mid; // [R1]
            aux_written_reg <= aux_written_reg || wr_aux; // [R1] [R14]
        end
    end

    // read mux from flops; unmapped words read zero
    always_comb begin
        rd_word = 16'h0000;
        unique case (dp_idx_reg)
            MID_CFG_IDX: rd_word = mid_cfg_reg;
            AUX_CFG_IDX: rd_word = aux_cfg_reg;
            STATUS_IDX: rd_word = {9'h000, pins_reg, mid_en, pcs_w.ready, mid_w.ready,
                                   aux_written_reg, mid_written_reg};
            default: rd_word = 16'h0000;
        endcase
    end
    assign o_hrdata = {16'h0000, rd_word};

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    assign mid_base = mid_cfg_reg[BASE_HI:BASE_LO]; // [R3]
    assign mid_size = aux_cfg_reg[SIZE_HI:SIZE_LO]; // [R10]
    assign pin_func = aux_cfg_reg[PIN_FUNC_BIT];
    assign space_mem = aux_cfg_reg[SPACE_BIT];
    assign mid_en = mid_written_reg && aux_written_reg; // [R1]

    // ------------------------------------------------------------------
    // address decode for the starting cycle
    // ------------------------------------------------------------------
    // a malformed size field gives odd decodes, not a lockup
    assign mid_hit = mid_en && i_mem_cycle && (mid_size != 7'h00)
                     && (((i_addr[19:13] ^ mid_base) & size_mask(mid_size)) == 7'h00); // [R3]
    assign mid_idx = quarter_idx(mid_size, i_addr); // [R21]
    assign pcs_cs_mode = aux_written_reg && pin_func && i_peripheral_base_valid; // [R12]
    assign pcs_addr_mode = aux_written_reg && !pin_func; // [R12] [R14]
    assign pcs_blk = pcs_cs_mode && (i_mem_cycle == space_mem) // [R15]
                     && (i_addr[19:11] == i_peripheral_base);
    assign pcs5_hit = pcs_blk && (i_addr[10:8] == PCS5_OFS);
    assign pcs6_hit = pcs_blk && (i_addr[10:8] == PCS6_OFS);
    assign pcs_hit = pcs5_hit || pcs6_hit;

    // ------------------------------------------------------------------
    // select outputs
    // ------------------------------------------------------------------
    // registered one edge after start, i.e. the later multiplexed-bus timing
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            lat_addr_reg <= 20'h00000;
            lat_mem_reg <= 1'b0;
            mid_sel_n_reg <= MID_OFF;
            pins_reg <= PINS_OFF;
            grp_reg <= 2'h0;
        end else if (i_ce) begin
            if (i_cyc_start) begin
                lat_addr_reg <= i_addr;
                lat_mem_reg <= i_mem_cycle;
                mid_sel_n_reg <= mid_hit ? ~(4'h1 << mid_idx) : MID_OFF; // [R2] [R21]
                grp_reg <= {pcs_hit, mid_hit};
                if (pcs_addr_mode) begin
                    pins_reg <= {i_addr[2], i_addr[1]}; // [R13]
                end else begin
                    pins_reg <= ~{pcs6_hit, pcs5_hit}; // [R12]
                end
            end else if (i_cyc_end) begin
                mid_sel_n_reg <= MID_OFF;
                grp_reg <= 2'h0;
                // latched address stays on the pins until the next cycle
                if (!pcs_addr_mode) begin
                    pins_reg <= PINS_OFF;
                end
            end else if (!pcs_addr_mode && !grp_reg[1]) begin
                // a stale latched address must not read as active selects after a mode change
                pins_reg <= PINS_OFF; // [R12]
            end
        end
    end
    assign o_midrange_selects_n = mid_sel_n_reg;
    assign o_upper_peripheral_pins = pins_reg;

    // ------------------------------------------------------------------
    // wait and ready sequencing
    // ------------------------------------------------------------------
    assign mid_w.start = i_cyc_start && mid_hit;
    assign mid_w.finish = i_cyc_end;
    assign mid_w.ext_ready = i_ext_ready;
    assign mid_w.ready_mode = mid_cfg_reg[READY_MODE_BIT]; // [R8]
    assign mid_w.wait_states = mid_cfg_reg[WAIT_HI:WAIT_LO]; // [R9]
    assign pcs_w.start = i_cyc_start && pcs_hit;
    assign pcs_w.finish = i_cyc_end;
    assign pcs_w.ext_ready = i_ext_ready;
    assign pcs_w.ready_mode = aux_cfg_reg[READY_MODE_BIT]; // [R16]
    assign pcs_w.wait_states = aux_cfg_reg[WAIT_HI:WAIT_LO]; // [R17]

    wait_sequencer u_mid_seq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .w(mid_w.seq)
    );

    wait_sequencer u_pcs_seq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .w(pcs_w.seq)
    );

    // cycles outside both groups are not held by this unit
    assign o_cycle_ready = grp_reg[0] ? mid_w.ready : (grp_reg[1] ? pcs_w.ready : 1'b1);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst || !i_ce);

    sequence s_mid_start;
        i_cyc_start && mid_hit;
    endsequence

    a_mid_gated_off: assert property ( // [R1]
        !(mid_written_reg && aux_written_reg) |=> o_midrange_selects_n == MID_OFF)
        else $error("midrange select active before both registers written");
    a_mid_one_only: assert property ( // [R21]
        o_midrange_selects_n != MID_OFF |-> $onehot(~o_midrange_selects_n))
        else $error("more than one midrange select active");
    a_mid_late_select: assert property ( // [R2]
        s_mid_start |-> o_midrange_selects_n == MID_OFF
        ##1 o_midrange_selects_n == ~(4'h1 << $past(mid_idx)))
        else $error("midrange select wrong or not one edge after start");
    a_mid_base_match: assert property ( // [R3]
        o_midrange_selects_n != MID_OFF |->
        ((lat_addr_reg[19:13] ^ mid_base) & size_mask(mid_size)) == 7'h00)
        else $error("midrange select outside programmed block");
    a_pins_latch_addr: assert property ( // [R13]
        i_cyc_start && pcs_addr_mode |=> o_upper_peripheral_pins == $past(i_addr[2:1]))
        else $error("upper pins do not show latched address bits");
    a_pcs_space_match: assert property ( // [R15]
        pcs_cs_mode && (o_upper_peripheral_pins != PINS_OFF) |-> lat_mem_reg == space_mem)
        else $error("peripheral select in wrong bus space");

    a_pins_idle_off: assert property ( // [R12]
        !i_cyc_start && !pcs_addr_mode && !grp_reg[1] |=> o_upper_peripheral_pins == PINS_OFF)
        else $error("upper pins active outside a peripheral cycle");
    a_mid_sel_release: assert property ( // [R2]
        i_cyc_end && !i_cyc_start |=> o_midrange_selects_n == MID_OFF)
        else $error("midrange select not released after cycle end");

endmodule

/* File: design/midrange_cs_pkg.sv */
// constants for the midrange select unit: register indices, field positions,
// reset values and the wait sequencer states.
// assumes a 32-bit ahb-lite register port and a 20-bit processor address.
package midrange_cs_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0] MID_CFG_IDX = 10'h0a6;
    localparam logic [9:0] AUX_CFG_IDX = 10'h0a8;
    localparam logic [9:0] STATUS_IDX = 10'h0aa;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BASE_HI = 15;
    localparam int BASE_LO = 9;
    localparam int SIZE_HI = 14;
    localparam int SIZE_LO = 8;
    localparam int PIN_FUNC_BIT = 7;
    localparam int SPACE_BIT = 6;
    localparam int READY_MODE_BIT = 2;
    localparam int WAIT_HI = 1;
    localparam int WAIT_LO = 0;

    // ------------------------------------------------------------------
    // offsets of the two upper peripheral selects inside the 2K block
    // ------------------------------------------------------------------
    localparam logic [2:0] PCS5_OFS = 3'h5;
    localparam logic [2:0] PCS6_OFS = 3'h6;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [3:0] MID_OFF = 4'hf;
    localparam logic [1:0] PINS_OFF = 2'h3;
    localparam logic [1:0] WAIT_RST = 2'h0;

    // ------------------------------------------------------------------
    // wait sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_COUNT = 2'b01,
        SEQ_READY = 2'b10
    } seq_state_e;

endpackage

/* File: design/wait_ctl_if.sv */
// control link between the select unit and one wait-state sequencer.
// assumes both ends run on the same processor clock.
`timescale 1ns/10ps
interface wait_ctl_if;
    logic start;
    logic finish;
    logic ext_ready;
    logic ready_mode;
    logic [1:0] wait_states;
    logic ready;

    modport seq (input start, input finish, input ext_ready, input ready_mode,
                 input wait_states, output ready);
    modport ctl (output start, output finish, output ext_ready, output ready_mode,
                 output wait_states, input ready);
endinterface

/* File: design/wait_sequencer.sv */
// wait-state and ready sequencer for one group of selects.
// assumes start comes once per bus cycle and finish ends that cycle.
`timescale 1ns/10ps
module wait_sequencer
    import midrange_cs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    wait_ctl_if.seq w
);

    seq_state_e state_reg, state_next;
    logic [1:0] count_reg, count_next;

    // ------------------------------------------------------------------
    // state and counter
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg <= SEQ_IDLE;
            count_reg <= WAIT_RST;
        end else if (i_ce) begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // programmed waits always run out before ready is even looked at
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            SEQ_IDLE: begin
                if (w.start) begin
                    count_next = w.wait_states;
                    state_next = SEQ_COUNT;
                end
            end
            SEQ_COUNT: begin
                if (w.finish) begin
                    state_next = SEQ_IDLE;
                end else if (count_reg != 2'h0) begin
                    count_next = count_reg - 2'h1; // [R9] [R17]
                end else if (w.ready_mode || w.ext_ready) begin
                    state_next = SEQ_READY; // [R8] [R16]
                end
            end
            SEQ_READY: begin
                if (w.finish) begin
                    state_next = SEQ_IDLE;
                end
            end
            default: begin
                state_next = SEQ_IDLE;
            end
        endcase
    end

    assign w.ready = (state_reg == SEQ_READY);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst || !i_ce);

    sequence s_start_three;
        w.start && w.ready_mode && (w.wait_states == 2'h3) && (state_reg == SEQ_IDLE);
    endsequence

    a_three_waits_end: assert property ( // [R9]
        s_start_three ##1 (!w.finish)[*4] |=> w.ready)
        else $error("ready not raised after three wait states");
    a_three_waits_hold: assert property ( // [R17]
        s_start_three |=> (!w.ready)[*4])
        else $error("ready raised before wait states ran out");
    a_ext_ready_needed: assert property ( // [R8]
        (state_reg == SEQ_COUNT) && (count_reg == 2'h0) && !w.ready_mode
        && !w.ext_ready && !w.finish |=> !w.ready)
        else $error("ready raised without external ready");

endmodule

/* File: bench/ext_memory_model.sv */
// model of the external memory and peripherals behind the selects.
// assumes the bench tells it which pins act as selects and how slow to be.
`timescale 1ns/10ps
module ext_memory_model (
    input wire logic i_clk,
    input wire logic [3:0] i_selects_n,
    input wire logic [1:0] i_pins,
    input wire logic i_pins_are_selects,
    input wire logic [3:0] i_delay,
    output logic o_ready
);
    // ------------------------------------------------------------------
    // access timer
    // ------------------------------------------------------------------
    logic [3:0] wait_reg;
    logic active;

    // a device answers only while one of its selects is low
    assign active = (i_selects_n != 4'hf) || (i_pins_are_selects && (i_pins != 2'h3));

    // counts cycles of the current access, saturating so it never wraps
    always_ff @(posedge i_clk) begin
        if (!active) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != 4'hf) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end

    // ready line is pulled low when no device drives it
    assign o_ready = active && (wait_reg >= i_delay);
endmodule

/* File: bench/tb.sv */
// self-checking bench for the midrange select unit.
// assumes a single ahb-lite master and one processor bus cycle at a time.
`timescale 1ns/10ps
module tb;
    import midrange_cs_pkg::*;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready, hresp, cycle_ready, ext_ready;
    logic [31:0] hrdata;
    logic cyc_start = 1'b0;
    logic cyc_end = 1'b0;
    logic [19:0] addr = 20'h0;
    logic mem_cycle = 1'b1;
    logic [8:0] peripheral_base = 9'h0;
    logic base_valid = 1'b0;
    logic [3:0] selects_n;
    logic [1:0] pins;
    logic addr_mode = 1'b1;
    logic [3:0] delay = 4'h0;
    logic [31:0] rd;
    int failures = 0;
    int comparisons = 0;

    always #10 clk = ~clk;

    midrange_chip_select_unit dut (.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_cyc_start(cyc_start), .i_cyc_end(cyc_end), .i_addr(addr),
        .i_mem_cycle(mem_cycle), .i_ext_ready(ext_ready), .i_peripheral_base(peripheral_base),
        .i_peripheral_base_valid(base_valid), .o_midrange_selects_n(selects_n),
        .o_upper_peripheral_pins(pins), .o_cycle_ready(cycle_ready));

    // selects reach the model directly: pad i/o mode and direction taken as cleared
    ext_memory_model mem (.i_clk(clk), .i_selects_n(selects_n), .i_pins(pins),
        .i_pins_are_selects(!addr_mode), .i_delay(delay), .o_ready(ext_ready));

    // ------------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single ahb transfer; waits for hready in both phases
    task automatic ahb(input logic wr, input logic [9:0] idx, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {20'h0, idx, 2'b00};
        n = 0;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            failures++;
            finish_test;
        end
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wdata;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 100);
        rdata = hrdata;
        if (n >= 100) begin
            failures++;
            finish_test;
        end
    endtask

    // reserved bits always ones; base fixed at 10000h, never zero
    function automatic logic [31:0] mid_val(input logic rm, input logic [1:0] ws);
        return 32'h11f8 | {29'h0, rm, ws};
    endfunction

    function automatic logic [31:0] aux_val(input logic [6:0] sz, input logic ex,
                                            input logic ms, input logic rm, input logic [1:0] ws);
        return 32'h8038 | {17'h0, sz, ex, ms, 3'h0, rm, ws};
    endfunction

    // one processor cycle; exp_k below zero means more than -exp_k edges to ready
    task automatic cyc(input logic [19:0] a, input logic mem_c, input logic [3:0] exp_sel,
                       input logic [1:0] exp_pins, input int exp_k);
        int k;
        logic [1:0] pin_exp;
        pin_exp = addr_mode ? a[2:1] : exp_pins;
        @(posedge clk);
        cyc_start <= 1'b1;
        addr <= a;
        mem_cycle <= mem_c;
        @(posedge clk);
        cyc_start <= 1'b0;
        #1;
        check({28'h0, selects_n}, {28'h0, exp_sel});
        check({30'h0, pins}, {30'h0, pin_exp});
        k = 0;
        while (cycle_ready !== 1'b1 && k < 40) begin @(posedge clk); k++; #1; end
        if (k >= 40) begin
            failures++;
            finish_test;
        end
        if (exp_k >= 0) check(32'(k), 32'(exp_k));
        else check({31'h0, k > -exp_k}, 32'h1);
        check({28'h0, selects_n}, {28'h0, exp_sel});
        @(posedge clk);
        cyc_end <= 1'b1;
        @(posedge clk);
        cyc_end <= 1'b0;
        #1;
        check({28'h0, selects_n}, 32'hf);
        check({30'h0, pins}, {30'h0, addr_mode ? a[2:1] : 2'h3});
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({28'h0, selects_n}, 32'hf);
        check({30'h0, pins}, 32'h3);
        check({31'h0, hresp}, 32'h0);
        ahb(1'b1, MID_CFG_IDX, mid_val(1'b1, 2'h0), rd);
        addr_mode = 1'b0;
        cyc(20'h10000, 1'b1, 4'hf, 2'h3, 0);
        $display("test reset done");
    endtask

    task automatic t_regs;
        ahb(1'b1, AUX_CFG_IDX, aux_val(7'h04, 1'b0, 1'b1, 1'b1, 2'h0), rd);
        addr_mode = 1'b1;
        ahb(1'b0, MID_CFG_IDX, 32'h0, rd);
        check(rd, mid_val(1'b1, 2'h0));
        ahb(1'b0, AUX_CFG_IDX, 32'h0, rd);
        check(rd, aux_val(7'h04, 1'b0, 1'b1, 1'b1, 2'h0));
        ahb(1'b1, 10'h0b0, 32'hffff, rd);
        ahb(1'b0, 10'h0b0, 32'h0, rd);
        check(rd, 32'h0);
        // status: pins idle, block enabled, no ready pending, both registers written
        ahb(1'b0, STATUS_IDX, 32'h0, rd);
        check(rd, 32'h73);
        $display("test registers done");
    endtask

    // 32K block at 10000h (aligned), then the smallest 8K block
    task automatic t_decode;
        for (int q = 0; q < 4; q++) begin
            cyc(20'h10123 + 20'(q) * 20'h2000, 1'b1, ~(4'h1 << q), 2'h0, 1);
        end
        cyc(20'h18000, 1'b1, 4'hf, 2'h0, 0);
        cyc(20'h10000, 1'b0, 4'hf, 2'h0, 0);
        ahb(1'b1, AUX_CFG_IDX, aux_val(7'h01, 1'b0, 1'b1, 1'b1, 2'h0), rd);
        cyc(20'h11802, 1'b1, 4'h7, 2'h0, 1);
        cyc(20'h12000, 1'b1, 4'hf, 2'h0, 0);
        ahb(1'b1, AUX_CFG_IDX, aux_val(7'h04, 1'b0, 1'b1, 1'b1, 2'h0), rd);
        $display("test decode done");
    endtask

    task automatic t_waits;
        for (int w = 0; w < 4; w++) begin
            ahb(1'b1, MID_CFG_IDX, mid_val(1'b1, 2'(w)), rd);
            cyc(20'h10000, 1'b1, 4'he, 2'h0, w + 1);
        end
        ahb(1'b1, MID_CFG_IDX, mid_val(1'b0, 2'h2), rd);
        cyc(20'h10000, 1'b1, 4'he, 2'h0, 3);
        delay <= 4'h6;
        ahb(1'b1, MID_CFG_IDX, mid_val(1'b0, 2'h1), rd);
        cyc(20'h10000, 1'b1, 4'he, 2'h0, -2);
        ahb(1'b1, MID_CFG_IDX, mid_val(1'b1, 2'h1), rd);
        cyc(20'h10000, 1'b1, 4'he, 2'h0, 2);
        delay <= 4'h0;
        $display("test wait states done");
    endtask

    // address mode needs no peripheral base at all
    task automatic t_addr_pins;
        cyc(20'h00002, 1'b1, 4'hf, 2'h0, 0);
        cyc(20'h00004, 1'b1, 4'hf, 2'h0, 0);
        $display("test address pins done");
    endtask

    task automatic t_pcs;
        peripheral_base <= 9'h040;
        base_valid <= 1'b1;
        ahb(1'b1, AUX_CFG_IDX, aux_val(7'h04, 1'b1, 1'b1, 1'b1, 2'h2), rd);
        addr_mode = 1'b0;
        // the address latched in address mode must not linger as active selects
        @(posedge clk);
        #1;
        check({30'h0, pins}, 32'h3);
        cyc(20'h20500, 1'b1, 4'hf, 2'h2, 3);
        cyc(20'h20600, 1'b0, 4'hf, 2'h3, 0);
        peripheral_base <= 9'h001;
        delay <= 4'h4;
        ahb(1'b1, AUX_CFG_IDX, aux_val(7'h04, 1'b1, 1'b0, 1'b0, 2'h0), rd);
        cyc(20'h00e00, 1'b0, 4'hf, 2'h1, -1);
        $display("test peripheral selects done");
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        t_reset;
        t_regs;
        t_decode;
        t_waits;
        t_addr_pins;
        t_pcs;
        finish_test;
    end
endmodule
